// file: hdl/msbc_top.sv
`timescale 1ns/1ns
// Operation
// - Sleep mode 0 keeps the device awake at all times.
// - Sleep mode 1 lets only the sleep request level govern sleep.
// - On request high: finish transfers, close connections, then enter low power.
// - Host drives sleep request low to wake; device then leaves low power.
// - Sleep mode 4 sleeps a set time, wakes a set time, repeats.
// - With flow control on, clear-to-send low when awake, high when asleep.
// - After bypass reboot association status reads 0x2F, otherwise another value.
// - In bypass, serial traffic passes both ways to the cellular AT port.
// - In bypass the device sends no probing commands of its own.
// - In bypass the device never starts a network connection itself.
// - Local command mode entry still works while bypass is active.
module msbc_top (
  input  logic                    clk,
  input  logic                    sys_rst,
  input  msbc_pkg::msbc_apb_req_t apb_req,
  output msbc_pkg::msbc_apb_rsp_t apb_rsp,
  input  logic                    sleep_request_pin,
  input  msbc_pkg::msbc_byte_t    host_rx,
  output logic                    host_rx_ready,
  output msbc_pkg::msbc_byte_t    host_tx,
  input  logic                    host_tx_ready,
  input  msbc_pkg::msbc_byte_t    cell_rx,
  output logic                    cell_rx_ready,
  output msbc_pkg::msbc_byte_t    cell_tx,
  input  logic                    cell_tx_ready,
  output logic                    cts_n,
  output logic                    close_conn,
  output logic                    low_power,
  output logic                    cell_probe,
  output logic                    cell_connect
);
  import msbc_pkg::*;

  msbc_state_t s_q;
  msbc_state_t s_d;
  logic        fwd_en;
  logic        paths_idle;

  // Forwarding only while bypass is up, awake and out of command mode.
  assign fwd_en = s_q.bypass & ~s_q.cmd_mode & ~s_q.booting & (s_q.pwr == PWR_AWAKE);

  // Nothing is in flight once both buffers are empty and neither takes a word.
  assign paths_idle = ~cell_tx.valid & ~host_tx.valid & ~host_rx_ready & ~cell_rx_ready;

  // Host serial port toward the cellular AT port.
  msbc_skid u_host2cell (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .en        (fwd_en),
    .in_word   (host_rx),
    .in_ready  (host_rx_ready),
    .out_word  (cell_tx),
    .out_ready (cell_tx_ready)
  );

  // Cellular AT port back toward the host serial port.
  msbc_skid u_cell2host (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .en        (fwd_en),
    .in_word   (cell_rx),
    .in_ready  (cell_rx_ready),
    .out_word  (host_tx),
    .out_ready (host_tx_ready)
  );

  // Next-state logic for the bus slave, settings, boot and power sequencing.
  always_comb
  begin
    logic        setup;
    logic        wr_commit;
    logic        mapped;
    logic        reconfig;
    logic        reboot;
    logic        awake;
    logic [7:0]  assoc;
    logic [31:0] rd;
    setup     = apb_req.psel & ~apb_req.penable;
    wr_commit = apb_req.psel & apb_req.penable & apb_req.pwrite & s_q.pready;
    mapped    = (apb_req.paddr == REG_CTRL) || (apb_req.paddr == REG_STATUS) ||
                (apb_req.paddr == REG_SLEEP_TIME) || (apb_req.paddr == REG_WAKE_TIME);
    reconfig  = 1'b0;
    reboot    = 1'b0;
    awake     = 1'b0;
    rd        = 32'h0000_0000;
    assoc     = ASSOC_ACTIVE;
    s_d       = s_q;

    // Two-stage synchroniser; only the second stage is used below.
    s_d.sreq_meta = sleep_request_pin;
    s_d.sreq_sync = s_q.sreq_meta;

    // Strobes last one cycle.
    s_d.close_conn = 1'b0;
    s_d.probe      = 1'b0;
    s_d.connect    = 1'b0;

    // Association status reflects the operating mode chosen at the last boot.
    if (s_q.booting)
      assoc = ASSOC_BOOTING;
    else if (s_q.bypass)
      assoc = ASSOC_BYPASS;
    else
      assoc = ASSOC_ACTIVE;

    // Read data are captured in the setup cycle and shown during the access.
    case (apb_req.paddr)
      REG_CTRL:
      begin
        rd[CTRL_SLP_LSB +: 3] = s_q.sleep_mode;
        rd[CTRL_FLOW_BIT]    = s_q.flow_en;
        rd[CTRL_OP_LSB +: 3] = s_q.op_stage;
      end
      REG_STATUS:
      begin
        rd[ST_ASSOC_LSB +: 8] = assoc;
        rd[ST_AWAKE_BIT]      = ~s_q.booting & (s_q.pwr == PWR_AWAKE);
        rd[ST_BYPASS_BIT]     = s_q.bypass;
        rd[ST_CMD_BIT]        = s_q.cmd_mode;
        rd[ST_SAVED_LSB +: 3] = s_q.op_saved;
        rd[ST_SREQ_BIT]       = s_q.sreq_sync;
      end
      REG_SLEEP_TIME: rd = s_q.sleep_time;
      REG_WAKE_TIME:  rd = s_q.wake_time;
      default:        rd = 32'h0000_0000;
    endcase

    // Zero-wait slave: ready in the access cycle, error on an unmapped address.
    s_d.pready  = setup;
    s_d.pslverr = setup & ~mapped;
    if (setup & ~apb_req.pwrite)
      s_d.prdata = rd;

    // Register writes take effect at the completing edge only.
    if (wr_commit)
    begin
      case (apb_req.paddr)
        REG_CTRL:
        begin
          s_d.sleep_mode = apb_req.pwdata[CTRL_SLP_LSB +: 3];
          s_d.flow_en    = apb_req.pwdata[CTRL_FLOW_BIT];
          s_d.op_stage   = apb_req.pwdata[CTRL_OP_LSB +: 3];
          reconfig       = (s_d.sleep_mode != s_q.sleep_mode);
          // Saving copies the staged operating mode into the retained copy.
          if (apb_req.pwdata[CTRL_SAVE_BIT])
            s_d.op_saved = s_d.op_stage;
          // Command mode entry is accepted in every operating mode.
          if (apb_req.pwdata[CTRL_CMD_IN])
            s_d.cmd_mode = 1'b1;
          else if (apb_req.pwdata[CTRL_CMD_OUT])
            s_d.cmd_mode = 1'b0;
          reboot = apb_req.pwdata[CTRL_BOOT_BIT];
        end
        REG_SLEEP_TIME:
        begin
          s_d.sleep_time = apb_req.pwdata;
          reconfig       = 1'b1;
        end
        REG_WAKE_TIME:
        begin
          s_d.wake_time = apb_req.pwdata;
          reconfig      = 1'b1;
        end
        default:
        begin
          reconfig = 1'b0;
        end
      endcase
    end

    // Boot: the saved mode decides bypass once the activation time has passed.
    if (s_q.booting)
    begin
      s_d.boot_cnt = s_q.boot_cnt + 12'h001;
      if (s_q.boot_cnt == BOOT_CYCLES - 12'h001)
      begin
        s_d.booting = 1'b0;
        s_d.bypass  = (s_q.op_saved == OPMODE_BYPASS);
      end
    end
    else
    begin
      case (s_q.pwr)
        PWR_AWAKE:
        begin
          s_d.timer = s_q.timer + 32'h0000_0001;
          if ((s_q.sleep_mode == SLP_PIN) && s_q.sreq_sync)
            s_d.pwr = PWR_DRAIN;
          else if ((s_q.sleep_mode == SLP_CYCLIC) && (s_q.timer >= s_q.wake_time))
            s_d.pwr = PWR_DRAIN;
          if (s_d.pwr != s_q.pwr)
            s_d.timer = 32'h0000_0000;
        end
        PWR_DRAIN:
        begin
          // Words already taken are delivered before connections close.
          if (paths_idle)
          begin
            s_d.pwr        = PWR_CLOSE;
            s_d.close_conn = 1'b1;
            s_d.timer      = 32'h0000_0000;
          end
        end
        PWR_CLOSE:
        begin
          s_d.timer = s_q.timer + 32'h0000_0001;
          if (s_q.timer >= {20'h00000, CLOSE_CYCLES - 12'h001})
          begin
            s_d.pwr   = PWR_SLEEP;
            s_d.timer = 32'h0000_0000;
          end
        end
        PWR_SLEEP:
        begin
          s_d.timer = s_q.timer + 32'h0000_0001;
          if ((s_q.sleep_mode == SLP_PIN) && !s_q.sreq_sync)
            s_d.pwr = PWR_AWAKE;
          else if ((s_q.sleep_mode == SLP_CYCLIC) && (s_q.timer >= s_q.sleep_time))
            s_d.pwr = PWR_AWAKE;
          if (s_d.pwr != s_q.pwr)
            s_d.timer = 32'h0000_0000;
        end
        default:
        begin
          s_d.pwr = PWR_AWAKE;
        end
      endcase
    end

    // The cyclic timer restarts whenever its settings change.
    if (reconfig)
      s_d.timer = 32'h0000_0000;

    // Own modem housekeeping exists only outside bypass.
    if (!s_q.booting && !s_q.bypass && (s_q.pwr == PWR_AWAKE))
    begin
      s_d.probe_cnt = s_q.probe_cnt + 12'h001;
      if (s_q.probe_cnt == PROBE_CYCLES - 12'h001)
      begin
        s_d.probe     = 1'b1;
        s_d.probe_cnt = 12'h000;
      end
      if (!s_q.connected)
      begin
        s_d.connect   = 1'b1;
        s_d.connected = 1'b1;
      end
    end

    // A forced reboot reloads the saved mode and restarts activation.
    if (reboot)
    begin
      s_d.booting   = 1'b1;
      s_d.boot_cnt  = 12'h000;
      s_d.bypass    = 1'b0;
      s_d.cmd_mode  = 1'b0;
      s_d.op_stage  = s_q.op_saved;
      s_d.pwr       = PWR_AWAKE;
      s_d.timer     = 32'h0000_0000;
      s_d.probe_cnt = 12'h000;
      s_d.connected = 1'b0;
    end

    // Any sleep mode other than pin or cyclic behaves as always awake.
    if ((s_q.sleep_mode != SLP_PIN) && (s_q.sleep_mode != SLP_CYCLIC))
    begin
      s_d.pwr   = PWR_AWAKE;
      s_d.timer = 32'h0000_0000;
    end

    // Pin levels follow the next state so they line up with the status bits.
    awake         = ~s_d.booting & (s_d.pwr == PWR_AWAKE);
    s_d.low_power = (s_d.pwr == PWR_SLEEP);
    s_d.cts_n     = s_d.flow_en & ~awake;
  end

  // State register.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      s_q <= MSBC_STATE_RST;
    else
      s_q <= s_d;
  end

  // Outputs come straight from the state register.
  assign apb_rsp      = '{pready: s_q.pready, pslverr: s_q.pslverr, prdata: s_q.prdata};
  assign cts_n        = s_q.cts_n;
  assign close_conn   = s_q.close_conn;
  assign low_power    = s_q.low_power;
  assign cell_probe   = s_q.probe;
  assign cell_connect = s_q.connect;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  // Steps of a sleep entry, pin-controlled or cyclic.
  sequence seq_drain_to_close;
    (s_q.pwr == PWR_DRAIN) ##1 (s_q.pwr == PWR_CLOSE);
  endsequence

  sequence seq_status_read;
    apb_req.psel && !apb_req.penable && !apb_req.pwrite && (apb_req.paddr == REG_STATUS);
  endsequence

  a_normal_stays_awake: assert property ((s_q.sleep_mode == SLP_NORMAL) |=> (s_q.pwr == PWR_AWAKE))
    else $error("Normal sleep mode left the awake state.");

  a_pin_sleep_start: assert property ((s_q.sleep_mode == SLP_PIN) && s_q.sreq_sync && !s_q.booting &&
    (s_q.pwr == PWR_AWAKE) && !$past(sys_rst) |=> (s_q.pwr == PWR_DRAIN) || (s_q.sleep_mode != SLP_PIN))
    else $error("Sleep request high did not start sleep preparation.");

  a_close_strobe: assert property (seq_drain_to_close |-> s_q.close_conn)
    else $error("Connections not closed on leaving drain.");

  a_sleep_order: assert property ($rose(s_q.low_power) |-> $past(s_q.pwr) == PWR_CLOSE)
    else $error("Low power entered without closing connections first.");

  a_pin_wake: assert property ((s_q.sleep_mode == SLP_PIN) && (s_q.pwr == PWR_SLEEP) && !s_q.sreq_sync
    |=> (s_q.pwr == PWR_AWAKE))
    else $error("Sleep request low did not wake the device.");

  a_cyclic_wake: assert property ((s_q.sleep_mode == SLP_CYCLIC) && (s_q.pwr == PWR_SLEEP) &&
    (s_q.timer >= s_q.sleep_time) |=> (s_q.pwr == PWR_AWAKE))
    else $error("Cyclic sleep did not wake after its sleep time.");

  a_cts_sleep: assert property (s_q.flow_en && s_q.low_power |-> s_q.cts_n)
    else $error("Clear-to-send asserted while asleep.");

  a_cts_awake: assert property (s_q.flow_en && !s_q.booting && (s_q.pwr == PWR_AWAKE) |-> !s_q.cts_n)
    else $error("Clear-to-send not asserted while awake.");

  a_bypass_status: assert property (seq_status_read |=>
    ((s_q.prdata[7:0] == ASSOC_BYPASS) == $past(s_q.bypass && !s_q.booting)))
    else $error("Association status does not match bypass state.");

  a_boot_mode: assert property ($fell(s_q.booting) |-> s_q.bypass == ($past(s_q.op_saved) == OPMODE_BYPASS))
    else $error("Boot did not apply the saved operating mode.");

  a_forward_gate: assert property (host_rx_ready || cell_rx_ready |-> $past(fwd_en))
    else $error("Serial path accepted data outside bypass forwarding.");

  a_no_own_traffic: assert property (s_q.bypass |=> !s_q.probe && !s_q.connect)
    else $error("Own modem traffic issued while in bypass.");

  a_cmd_in_bypass: assert property (s_q.bypass && apb_req.psel && apb_req.penable && apb_req.pwrite &&
    s_q.pready && (apb_req.paddr == REG_CTRL) && apb_req.pwdata[CTRL_CMD_IN] &&
    !apb_req.pwdata[CTRL_BOOT_BIT] |=> s_q.cmd_mode)
    else $error("Command mode entry refused in bypass.");

  a_sync_depth: assert property (!$past(sys_rst) && !$past(sys_rst, 2) |->
    s_q.sreq_sync == $past(sleep_request_pin, 2))
    else $error("Sleep request not passed through two stages.");

endmodule : msbc_top

// file: hdl/msbc_pkg.sv
package msbc_pkg;

  // Clock rate used to turn times into cycle counts.
  localparam int CLK_MHZ = 250;

  // Register byte offsets.
  localparam logic [11:0] REG_CTRL       = 12'h000;
  localparam logic [11:0] REG_STATUS     = 12'h004;
  localparam logic [11:0] REG_SLEEP_TIME = 12'h008;
  localparam logic [11:0] REG_WAKE_TIME  = 12'h00c;

  // Control register fields.
  localparam int CTRL_SLP_LSB   = 0;
  localparam int CTRL_FLOW_BIT  = 3;
  localparam int CTRL_OP_LSB    = 4;
  localparam int CTRL_SAVE_BIT  = 8;
  localparam int CTRL_BOOT_BIT  = 9;
  localparam int CTRL_CMD_IN    = 10;
  localparam int CTRL_CMD_OUT   = 11;

  // Status register fields.
  localparam int ST_ASSOC_LSB   = 0;
  localparam int ST_AWAKE_BIT   = 8;
  localparam int ST_BYPASS_BIT  = 9;
  localparam int ST_CMD_BIT     = 10;
  localparam int ST_SAVED_LSB   = 11;
  localparam int ST_SREQ_BIT    = 14;

  // Mode encodings.
  localparam logic [2:0] SLP_NORMAL    = 3'h0;
  localparam logic [2:0] SLP_PIN       = 3'h1;
  localparam logic [2:0] SLP_CYCLIC    = 3'h4;
  localparam logic [2:0] OPMODE_BYPASS = 3'h5;

  // Association status values.
  localparam logic [7:0] ASSOC_BYPASS  = 8'h2f;
  localparam logic [7:0] ASSOC_ACTIVE  = 8'h00;
  localparam logic [7:0] ASSOC_BOOTING = 8'hff;

  // Reset values.
  localparam logic [2:0]  SLP_RST        = 3'h0;
  localparam logic [2:0]  OP_MODE_RST    = 3'h0;
  localparam logic [31:0] SLEEP_TIME_RST = 32'h0000_1000;
  localparam logic [31:0] WAKE_TIME_RST  = 32'h0000_0100;

  // Timing: boot and bypass activation, connection close, probe period.
  localparam int          BOOT_US      = 10;
  localparam logic [11:0] BOOT_CYCLES  = 12'(BOOT_US * CLK_MHZ);
  localparam int          CLOSE_NS     = 400;
  localparam logic [11:0] CLOSE_CYCLES = 12'(CLOSE_NS * CLK_MHZ / 1000);
  localparam int          PROBE_US     = 8;
  localparam logic [11:0] PROBE_CYCLES = 12'(PROBE_US * CLK_MHZ);

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } msbc_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } msbc_apb_rsp_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } msbc_byte_t;

  typedef enum logic [1:0] {PWR_AWAKE, PWR_DRAIN, PWR_CLOSE, PWR_SLEEP} msbc_pwr_t;

  typedef struct packed {
    msbc_byte_t out;
    msbc_byte_t skid;
    logic       in_ready;
  } msbc_skid_state_t;

  typedef struct packed {
    logic        sreq_meta;
    logic        sreq_sync;
    msbc_pwr_t   pwr;
    logic [31:0] timer;
    logic [2:0]  sleep_mode;
    logic        flow_en;
    logic [2:0]  op_stage;
    logic [2:0]  op_saved;
    logic        booting;
    logic [11:0] boot_cnt;
    logic        bypass;
    logic        cmd_mode;
    logic [31:0] sleep_time;
    logic [31:0] wake_time;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic        cts_n;
    logic        close_conn;
    logic        low_power;
    logic        probe;
    logic        connect;
    logic [11:0] probe_cnt;
    logic        connected;
  } msbc_state_t;

  localparam msbc_skid_state_t MSBC_SKID_RST = '{default: '0};
  localparam msbc_state_t MSBC_STATE_RST = '{pwr: PWR_AWAKE, booting: 1'b1, sleep_mode: SLP_RST,
                                            op_stage: OP_MODE_RST, op_saved: OP_MODE_RST,
                                            sleep_time: SLEEP_TIME_RST, wake_time: WAKE_TIME_RST,
                                            default: '0};

endpackage : msbc_pkg

// file: hdl/msbc_skid.sv
`timescale 1ns/1ns
module msbc_skid (
  input  logic                 clk,
  input  logic                 sys_rst,
  input  logic                 en,
  input  msbc_pkg::msbc_byte_t in_word,
  output logic                 in_ready,
  output msbc_pkg::msbc_byte_t out_word,
  input  logic                 out_ready
);
  import msbc_pkg::*;

  msbc_skid_state_t s_q;
  msbc_skid_state_t s_d;
  logic             take;
  logic             pop;

  // Handshakes on each side; ready is a flop, so a second word needs the skid slot.
  assign take = in_word.valid & s_q.in_ready;
  assign pop  = s_q.out.valid & out_ready;

  // Two entries: the output word and one skid word that absorbs the ready lag.
  always_comb
  begin
    s_d = s_q;
    if (pop)
    begin
      if (s_q.skid.valid)
      begin
        s_d.out  = s_q.skid;
        s_d.skid = '0;
        if (take)
          s_d.skid = in_word;
      end
      else if (take)
        s_d.out = in_word;
      else
        s_d.out = '0;
    end
    else if (take)
    begin
      if (!s_q.out.valid)
        s_d.out = in_word;
      else
        s_d.skid = in_word;
    end
    s_d.in_ready = en & ~s_d.skid.valid & ~(s_d.out.valid & ~en);
  end

  // State register.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      s_q <= MSBC_SKID_RST;
    else
      s_q <= s_d;
  end

  assign in_ready = s_q.in_ready;
  assign out_word = s_q.out;

endmodule : msbc_skid

// file: verification/msbc_host_model.sv
`timescale 1ns/1ns
// Host stand-in: feeds serial bytes, drains replies with random stalls and drives the sleep pin.
module msbc_host_model (
  input  logic                 clk,
  input  logic                 sys_rst,
  input  logic                 stall,
  input  logic                 want_sleep,
  output logic                 sleep_request_pin,
  output msbc_pkg::msbc_byte_t host_rx,
  input  logic                 host_rx_ready,
  input  msbc_pkg::msbc_byte_t host_tx,
  output logic                 host_tx_ready
);
  import msbc_pkg::*;

  logic [7:0] sendq[$];
  logic [7:0] recvq[$];

  initial
  begin
    sleep_request_pin = 1'b0;
    host_rx           = '0;
    host_tx_ready     = 1'b0;
  end

  // A byte holds until taken; an idle line toggles so a stale byte is never mistaken for data.
  always @(posedge clk)
  begin
    sleep_request_pin <= want_sleep;
    host_tx_ready     <= !stall && ($urandom % 4 != 0);
    if (sys_rst)
      host_rx <= '0;
    else if (!host_rx.valid || host_rx_ready)
    begin
      if (sendq.size() > 0)
        host_rx <= {1'b1, sendq.pop_front()};
      else
        host_rx <= {1'b0, ~host_rx.data};
    end
    if (!sys_rst && host_tx.valid === 1'b1 && host_tx_ready)
      recvq.push_back(host_tx.data);
  end
endmodule : msbc_host_model

// file: verification/msbc_top_test.sv
`timescale 1ns/1ns
module msbc_top_test;
  import msbc_pkg::*;

  localparam int SLP = 300;
  localparam int WK  = 200;

  logic          clk           = 1'b0;
  logic          sys_rst       = 1'b1;
  logic          stall         = 1'b0;
  logic          want_sleep    = 1'b0;
  logic          cell_tx_ready = 1'b0;
  msbc_apb_req_t req           = '0;
  msbc_byte_t    cell_rx       = '0;
  msbc_apb_rsp_t rsp;
  msbc_byte_t    host_rx;
  msbc_byte_t    host_tx;
  msbc_byte_t    cell_tx;
  logic          sleep_request_pin;
  logic          host_rx_ready;
  logic          host_tx_ready;
  logic          cell_rx_ready;
  logic          cts_n;
  logic          close_conn;
  logic          low_power;
  logic          cell_probe;
  logic          cell_connect;
  int            miscompares   = 0;
  int            check_count   = 0;
  int            probes        = 0;
  int            connects      = 0;
  int            lp_seen       = 0;
  int            p0;
  int            c0;
  int            n;
  logic [31:0]   rdata;
  logic          err;
  logic [7:0]    b;
  logic [7:0]    cq[$];
  logic [7:0]    expq[$];

  always #2 clk = ~clk;

  msbc_top dut_u (
    .clk               (clk),
    .sys_rst           (sys_rst),
    .apb_req           (req),
    .apb_rsp           (rsp),
    .sleep_request_pin (sleep_request_pin),
    .host_rx           (host_rx),
    .host_rx_ready     (host_rx_ready),
    .host_tx           (host_tx),
    .host_tx_ready     (host_tx_ready),
    .cell_rx           (cell_rx),
    .cell_rx_ready     (cell_rx_ready),
    .cell_tx           (cell_tx),
    .cell_tx_ready     (cell_tx_ready),
    .cts_n             (cts_n),
    .close_conn        (close_conn),
    .low_power         (low_power),
    .cell_probe        (cell_probe),
    .cell_connect      (cell_connect)
  );

  msbc_host_model host_u (
    .clk               (clk),
    .sys_rst           (sys_rst),
    .stall             (stall),
    .want_sleep        (want_sleep),
    .sleep_request_pin (sleep_request_pin),
    .host_rx           (host_rx),
    .host_rx_ready     (host_rx_ready),
    .host_tx           (host_tx),
    .host_tx_ready     (host_tx_ready)
  );

  // Cellular port stand-in echoes every byte back, so one stream exercises both directions.
  always @(posedge clk)
  begin
    cell_tx_ready <= !stall && ($urandom % 4 != 0);
    if (cell_tx.valid === 1'b1 && cell_tx_ready)
      cq.push_back(cell_tx.data);
    if (sys_rst)
      cell_rx <= '0;
    else if (!cell_rx.valid || cell_rx_ready)
    begin
      if (cq.size() > 0)
        cell_rx <= {1'b1, cq.pop_front()};
      else
        cell_rx <= {1'b0, ~cell_rx.data};
    end
  end

  // Running counts let quiet stretches be judged afterwards by difference.
  always @(posedge clk)
  begin
    probes   <= probes + int'(cell_probe === 1'b1);
    connects <= connects + int'(cell_connect === 1'b1);
    lp_seen  <= lp_seen + int'(low_power === 1'b1);
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wrap_up();
    if (miscompares == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : wrap_up

  task automatic timeout();
    miscompares++;
    $display("Error at %0t: seen %h expected %h", $time, 32'h0, 32'h1);
    wrap_up();
  endtask : timeout

  function automatic logic [31:0] ctrl(input logic [2:0] mode, input logic fl, input logic [2:0] op,
                                       input logic sv, input logic bt);
    logic [31:0] w;
    w = '0;
    w[CTRL_SLP_LSB +: 3] = mode;
    w[CTRL_FLOW_BIT]    = fl;
    w[CTRL_OP_LSB +: 3] = op;
    w[CTRL_SAVE_BIT]    = sv;
    w[CTRL_BOOT_BIT]    = bt;
    return w;
  endfunction : ctrl

  function automatic logic sig(input int k);
    case (k)
      0: return low_power;
      1: return close_conn;
      default: return host_rx_ready;
    endcase
  endfunction : sig

  // Request held until pready is seen at an edge; the idle cycle after keeps strobes from doubling up.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int k;
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
    @(posedge clk);
    req.penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (rsp.pready !== 1'b1 && k < 16);
    if (rsp.pready !== 1'b1)
      timeout();
    rdata = rsp.prdata;
    err   = rsp.pslverr;
    req.psel    <= 1'b0;
    req.penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic wait_on(input int k, input logic lvl, input int lim);
    int i;
    for (i = 0; i < lim; i++)
    begin
      @(posedge clk);
      if (sig(k) === lvl)
        return;
    end
    timeout();
  endtask : wait_on

  task automatic reboot(input logic [2:0] op);
    apb(1'b1, REG_CTRL, ctrl(SLP_NORMAL, 1'b0, op, 1'b1, 1'b0));
    apb(1'b1, REG_CTRL, ctrl(SLP_NORMAL, 1'b0, op, 1'b0, 1'b1));
    repeat (int'(BOOT_CYCLES) + 20) @(posedge clk);
    apb(1'b0, REG_STATUS, 32'h0);
  endtask : reboot

  initial
  begin
    repeat (100000) @(posedge clk);
    timeout();
  end

  initial
  begin
    void'($urandom(32'h8ce3));
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    apb(1'b0, REG_STATUS, 32'h0);
    check(rdata[7:0] != ASSOC_BYPASS, 1'b1);
    apb(1'b0, 12'h010, 32'h0);
    check(err, 1'b1);
    repeat (int'(BOOT_CYCLES) + 20) @(posedge clk);
    apb(1'b0, REG_STATUS, 32'h0);
    check(rdata[ST_AWAKE_BIT], 1'b1);
    // Normal mode must shrug off a sleep request.
    p0 = lp_seen;
    want_sleep <= 1'b1;
    repeat (300) @(posedge clk);
    check(lp_seen - p0, 0);
    // Pin sleep with the request already high: close first, then low power with clear-to-send high.
    apb(1'b1, REG_CTRL, ctrl(SLP_PIN, 1'b1, 3'h0, 1'b0, 1'b0));
    wait_on(1, 1'b1, 500);
    check(low_power, 1'b0);
    wait_on(0, 1'b1, 500);
    check(cts_n, 1'b1);
    want_sleep <= 1'b0;
    wait_on(0, 1'b0, 50);
    check(cts_n, 1'b0);
    // Cyclic sleep repeats with the programmed sleep length.
    apb(1'b1, REG_SLEEP_TIME, SLP);
    apb(1'b1, REG_WAKE_TIME, WK);
    apb(1'b1, REG_CTRL, ctrl(SLP_CYCLIC, 1'b1, 3'h0, 1'b0, 1'b0));
    repeat (2)
    begin
      wait_on(0, 1'b1, 1000);
      n = 0;
      while (low_power === 1'b1 && n < 2000)
      begin
        @(posedge clk);
        n++;
      end
      check(n >= SLP - 1 && n <= SLP + 3, 1'b1);
    end
    // Enter bypass: stage, save, reboot; own probes and connects must stay silent.
    c0 = connects;
    reboot(OPMODE_BYPASS);
    // Probes are counted from bypass activation only; one may fall just before the reboot lands.
    p0 = probes;
    check(rdata[7:0], ASSOC_BYPASS);
    check(rdata[ST_BYPASS_BIT], 1'b1);
    // Both far ends stall so the buffers fill and the host side is refused.
    stall <= 1'b1;
    for (int i = 0; i < 32; i++)
    begin
      b = 8'($urandom);
      if (i == 0)
        b = 8'hff;
      host_u.sendq.push_back(b);
      expq.push_back(b);
      if (i == 8)
      begin
        repeat (20) @(posedge clk);
        check(host_rx_ready, 1'b0);
        stall <= 1'b0;
      end
    end
    for (n = 0; n < 2000 && host_u.recvq.size() < expq.size(); n++)
      @(posedge clk);
    check(host_u.recvq.size(), expq.size());
    foreach (expq[i])
      check(host_u.recvq[i], expq[i]);
    apb(1'b1, REG_CTRL, ctrl(SLP_NORMAL, 1'b0, OPMODE_BYPASS, 1'b0, 1'b0) | (32'h1 << CTRL_CMD_IN));
    apb(1'b0, REG_STATUS, 32'h0);
    check(rdata[ST_CMD_BIT], 1'b1);
    apb(1'b1, REG_CTRL, ctrl(SLP_NORMAL, 1'b0, OPMODE_BYPASS, 1'b0, 1'b0) | (32'h1 << CTRL_CMD_OUT));
    // Stay in bypass longer than one probe period, so a probe that leaked through would be seen.
    repeat (int'(PROBE_CYCLES) + 10) @(posedge clk);
    check(probes - p0, 0);
    check(connects - c0, 0);
    // Leave bypass the same way.
    reboot(3'h0);
    check(rdata[7:0] != ASSOC_BYPASS, 1'b1);
    check(rdata[ST_BYPASS_BIT], 1'b0);
    wrap_up();
  end
endmodule : msbc_top_test
